// file: rtl/lrc_pkg.sv
// Package for the linear regulator control block: register map, field layout, reset values.
// Assumes a 32-bit AXI4-Lite register bus and four regulators.
package lrc_pkg;
	localparam int          LRC_NUM_REG      = 4;
	localparam int          LRC_CODE_W       = 4;
	// Byte offsets
	localparam logic [7:0]  LRC_OFS_SYS      = 8'h00;
	localparam logic [7:0]  LRC_OFS_ENABLE   = 8'h04;
	localparam logic [7:0]  LRC_OFS_RUN_V    = 8'h08;
	localparam logic [7:0]  LRC_OFS_STBY_V   = 8'h0c;
	localparam logic [7:0]  LRC_OFS_STATUS   = 8'h10;
	// SYS fields
	localparam int          LRC_SYS_STBY_BIT = 0;
	localparam int          LRC_SYS_HW2_BIT  = 1;
	// ENABLE fields: run enables in [3:0], standby enables in [7:4]
	localparam int          LRC_EN_RUN_LSB   = 0;
	localparam int          LRC_EN_STBY_LSB  = 4;
	// Reset values and bus response codes
	localparam logic [1:0]  LRC_SYS_RST      = 2'h0;
	localparam logic [1:0]  LRC_RESP_OKAY    = 2'h0;
	localparam logic [1:0]  LRC_RESP_SLVERR  = 2'h2;
	// Regulator operating state
	typedef enum logic [1:0] {
		LRC_OFF_PULLDOWN,
		LRC_REGULATE,
		LRC_LOAD_SWITCH
	} lrc_state_t;
	// Output voltage in millivolts per code
	function automatic logic [12:0] lrc_code_mv(input logic [3:0] code);
		case (code)
			4'h0:    lrc_code_mv = 13'd1500;
			4'h1:    lrc_code_mv = 13'd1600;
			4'h2:    lrc_code_mv = 13'd1800;
			4'h3:    lrc_code_mv = 13'd1850;
			4'h4:    lrc_code_mv = 13'd2150;
			4'h5:    lrc_code_mv = 13'd2500;
			4'h6:    lrc_code_mv = 13'd2800;
			4'h7:    lrc_code_mv = 13'd3000;
			4'h8:    lrc_code_mv = 13'd3100;
			4'h9:    lrc_code_mv = 13'd3150;
			4'ha:    lrc_code_mv = 13'd3200;
			4'hb:    lrc_code_mv = 13'd3300;
			4'hc:    lrc_code_mv = 13'd3350;
			4'hd:    lrc_code_mv = 13'd1650;
			4'he:    lrc_code_mv = 13'd1700;
			default: lrc_code_mv = 13'd5000;
		endcase
	endfunction
endpackage

// file: rtl/lrc_top.sv
// Digital control for four linear regulators, with AXI4-Lite registers.
// Assumes fused settings are stable from reset onward; hardware pins are asynchronous.
`timescale 1ns/10ps

// Functional notes
// RULE1 - Run mode: run enable zero disables regulator
// RULE2 - Standby: standby enable zero disables regulator
// RULE3 - Enables preset by power-up sequence, else zero
// RULE4 - Enable zero: off with pull-down active
// RULE5 - Enable one, switch select zero: regulate
// RULE6 - Enable one, switch select one: pass-through
// RULE7 - Load-switch select comes from fused bit
// RULE8 - Separate run and standby codes, mode-selected
// RULE9 - Both codes loaded from fused default
// RULE10 - Code decodes to documented voltage table
// RULE11 - Regulator two controllable by hardware pins
// RULE12 - Follow enable pin and select pin
// RULE13 - Load switch opens/closes per enable
// RULE14 - Select pin picks one of two presets
module lrc_top
	import lrc_pkg::*;
#(
	parameter int N = lrc_pkg::LRC_NUM_REG
) (
	// Clock and reset
	input  wire logic                        core_clk,
	input  wire logic                        rst,
	// Fused settings
	input  wire logic [N-1:0]                fused_load_switch_select,
	input  wire logic [N*4-1:0]              fused_voltage_default,
	input  wire logic [N-1:0]                fused_in_sequence,
	input  wire logic [3:0]                  fused_reg2_alt_code,
	// Hardware pins for regulator two
	input  wire logic                        second_regulator_enable_pin,
	input  wire logic                        voltage_choice_pin,
	// AXI4-Lite write address
	input  wire logic [7:0]                  s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [7:0]                  s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	// Regulator controls
	output lrc_pkg::lrc_state_t [N-1:0]      reg_state,
	output logic [N*4-1:0]                   reg_code,
	output logic [N*13-1:0]                  reg_mv
);
	import lrc_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	// Only the second stage is read, so a metastable first stage never reaches logic
	logic [1:0] en_sync;
	logic [1:0] sel_sync;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			en_sync  <= 2'h0;
			sel_sync <= 2'h0;
		end else begin
			en_sync  <= {en_sync[0], second_regulator_enable_pin};
			sel_sync <= {sel_sync[0], voltage_choice_pin};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register state
	logic [1:0]      sys;
	logic [N-1:0]    run_mode_enable_bit;
	logic [N-1:0]    standby_mode_enable_bit;
	logic [N*4-1:0]  run_voltage_code;
	logic [N*4-1:0]  standby_voltage_code;
	logic            loaded;
	logic            aw_held;
	logic            w_held;
	logic [7:0]      aw_addr;
	logic [31:0]     w_data;
	logic [3:0]      w_strb;

	logic [1:0]      next_sys;
	logic [N-1:0]    next_run_en;
	logic [N-1:0]    next_stby_en;
	logic [N*4-1:0]  next_run_code;
	logic [N*4-1:0]  next_stby_code;
	logic            next_loaded;
	logic            next_aw_held;
	logic            next_w_held;
	logic [7:0]      next_aw_addr;
	logic [31:0]     next_w_data;
	logic [3:0]      next_w_strb;
	logic            next_bvalid;
	logic [1:0]      next_bresp;
	logic            next_rvalid;
	logic [31:0]     next_rdata;
	logic [1:0]      next_rresp;

	logic [31:0]     wmask;

	function automatic logic [31:0] strb_mask(input logic [3:0] s);
		strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
		merge = (old & ~m) | (nw & m);
	endfunction

	always_comb begin
		next_sys       = sys;
		next_run_en    = run_mode_enable_bit;
		next_stby_en   = standby_mode_enable_bit;
		next_run_code  = run_voltage_code;
		next_stby_code = standby_voltage_code;
		next_loaded    = 1'b1;
		next_aw_held   = aw_held;
		next_w_held    = w_held;
		next_aw_addr   = aw_addr;
		next_w_data    = w_data;
		next_w_strb    = w_strb;
		next_bvalid    = s_axi_bvalid;
		next_bresp     = s_axi_bresp;
		next_rvalid    = s_axi_rvalid;
		next_rdata     = s_axi_rdata;
		next_rresp     = s_axi_rresp;
		wmask          = strb_mask(w_strb);
		// Fused defaults are captured one edge after reset release, never under reset
		// The bus stays shut until then, since every ready waits for loaded
		if (!loaded) begin
			next_run_en    = fused_in_sequence; // RULE3
			next_stby_en   = fused_in_sequence; // RULE3
			next_run_code  = fused_voltage_default; // RULE9
			next_stby_code = fused_voltage_default; // RULE9
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				next_aw_held = 1'b1;
				next_aw_addr = s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				next_w_held = 1'b1;
				next_w_data = s_axi_wdata;
				next_w_strb = s_axi_wstrb;
			end
			if (aw_held && w_held && !s_axi_bvalid) begin
				next_aw_held = 1'b0;
				next_w_held  = 1'b0;
				next_bvalid  = 1'b1;
				next_bresp   = LRC_RESP_OKAY;
				// Unmapped offsets answer with an error and change nothing
				case (aw_addr)
					LRC_OFS_SYS: next_sys = 2'(merge(32'(sys), w_data, wmask));
					LRC_OFS_ENABLE: begin
						next_run_en  = N'(merge(32'(run_mode_enable_bit), w_data >> LRC_EN_RUN_LSB, wmask));
						next_stby_en = N'(merge(32'(standby_mode_enable_bit), w_data >> LRC_EN_STBY_LSB,
							wmask >> LRC_EN_STBY_LSB));
					end
					LRC_OFS_RUN_V:  next_run_code  = (N*4)'(merge(32'(run_voltage_code), w_data, wmask)); // RULE8
					LRC_OFS_STBY_V: next_stby_code = (N*4)'(merge(32'(standby_voltage_code), w_data, wmask)); // RULE8
					LRC_OFS_STATUS: ;
					default: next_bresp = LRC_RESP_SLVERR;
				endcase
			end
			if (s_axi_bvalid && s_axi_bready) begin
				next_bvalid = 1'b0;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				next_rvalid = 1'b1;
				next_rresp  = LRC_RESP_OKAY;
				case (s_axi_araddr)
					LRC_OFS_SYS:    next_rdata = 32'(sys);
					LRC_OFS_ENABLE: next_rdata = 32'({standby_mode_enable_bit, run_mode_enable_bit});
					LRC_OFS_RUN_V:  next_rdata = 32'(run_voltage_code);
					LRC_OFS_STBY_V: next_rdata = 32'(standby_voltage_code);
					LRC_OFS_STATUS: next_rdata = 32'(reg_state);
					default: begin
						next_rdata = 32'h0;
						next_rresp = LRC_RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				next_rvalid = 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sys                     <= LRC_SYS_RST;
			run_mode_enable_bit     <= '0;
			standby_mode_enable_bit <= '0;
			run_voltage_code        <= '0;
			standby_voltage_code    <= '0;
			loaded                  <= 1'b0;
			aw_held                 <= 1'b0;
			w_held                  <= 1'b0;
			aw_addr                 <= 8'h00;
			w_data                  <= 32'h0;
			w_strb                  <= 4'h0;
			s_axi_bvalid            <= 1'b0;
			s_axi_bresp             <= LRC_RESP_OKAY;
			s_axi_rvalid            <= 1'b0;
			s_axi_rdata             <= 32'h0;
			s_axi_rresp             <= LRC_RESP_OKAY;
		end else begin
			sys                     <= next_sys;
			run_mode_enable_bit     <= next_run_en;
			standby_mode_enable_bit <= next_stby_en;
			run_voltage_code        <= next_run_code;
			standby_voltage_code    <= next_stby_code;
			loaded                  <= next_loaded;
			aw_held                 <= next_aw_held;
			w_held                  <= next_w_held;
			aw_addr                 <= next_aw_addr;
			w_data                  <= next_w_data;
			w_strb                  <= next_w_strb;
			s_axi_bvalid            <= next_bvalid;
			s_axi_bresp             <= next_bresp;
			s_axi_rvalid            <= next_rvalid;
			s_axi_rdata             <= next_rdata;
			s_axi_rresp             <= next_rresp;
		end
	end

	// Ready outputs are registered; each write channel accepts one beat until the write completes
	// Readies follow next-state values so a held beat is never taken twice
	logic next_awready;
	logic next_wready;
	logic next_arready;
	always_comb begin
		next_awready = loaded && !next_aw_held && !next_bvalid;
		next_wready  = loaded && !next_w_held && !next_bvalid;
		next_arready = loaded && !next_rvalid;
	end
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_arready <= 1'b0;
		end else begin
			s_axi_awready <= next_awready;
			s_axi_wready  <= next_wready;
			s_axi_arready <= next_arready;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Regulator state decode
	lrc_state_t [N-1:0] next_state;
	logic [N*4-1:0]     next_code;
	logic [N*13-1:0]    next_mv;
	always_comb begin
		logic       en;
		logic [3:0] code;
		en   = 1'b0;
		code = 4'h0;
		for (int i = 0; i < N; i++) begin
			// Standby bit picks enable and code of the current mode
			en   = sys[LRC_SYS_STBY_BIT] ? standby_mode_enable_bit[i] : run_mode_enable_bit[i]; // RULE1 RULE2
			code = sys[LRC_SYS_STBY_BIT] ? standby_voltage_code[i*4 +: 4] : run_voltage_code[i*4 +: 4]; // RULE8
			if (i == 1 && sys[LRC_SYS_HW2_BIT]) begin
				en   = en_sync[1]; // RULE11 RULE12
				// Low picks the register code of the current mode, high the fused alternate
				code = sel_sync[1] ? fused_reg2_alt_code : code; // RULE12 RULE14
			end
			// Fused switch select is static, so it needs no synchroniser
			if (!en) begin
				next_state[i] = LRC_OFF_PULLDOWN; // RULE4
			end else if (fused_load_switch_select[i]) begin
				next_state[i] = LRC_LOAD_SWITCH; // RULE6 RULE7 RULE13
			end else begin
				next_state[i] = LRC_REGULATE; // RULE5
			end
			next_code[i*4 +: 4]  = code;
			next_mv[i*13 +: 13]  = lrc_code_mv(code); // RULE10
		end
	end
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			// Regulators leave reset off, with their pull-downs active
			reg_state <= '{default: LRC_OFF_PULLDOWN};
			reg_code  <= '0;
			reg_mv    <= '0;
		end else begin
			reg_state <= next_state;
			reg_code  <= next_code;
			reg_mv    <= next_mv;
		end
	end
endmodule

// file: test/lrc_top_chk.sv
// Port-level assertions for the regulator control block.
// Assumes it is bound onto lrc_top; regulators 0, 1 and 2 stand in for the rest.
`timescale 1ns/10ps
module lrc_chk
	import lrc_pkg::*;
#(
	parameter int N = 4
) (
	// Clock and reset
	input wire logic			core_clk,
	input wire logic			rst,
	// Fused settings
	input wire logic [N-1:0]		fused_load_switch_select,
	input wire logic [N*4-1:0]		fused_voltage_default,
	input wire logic [N-1:0]		fused_in_sequence,
	// Read channel
	input wire logic			s_axi_arvalid,
	input wire logic			s_axi_arready,
	input wire logic			s_axi_rvalid,
	// Regulator controls
	input wire lrc_state_t [N-1:0]	reg_state,
	input wire logic [N*4-1:0]		reg_code,
	input wire logic [N*13-1:0]		reg_mv
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	property p_mv_d; reg_code[3:0] == 4'hd |-> reg_mv[12:0] == 13'd1650; endproperty
	a_mv_d: assert property (p_mv_d) else $error("code d voltage wrong");
	property p_mv_f; reg_code[7:4] == 4'hf |-> reg_mv[25:13] == 13'd5000; endproperty
	a_mv_f: assert property (p_mv_f) else $error("code f voltage wrong");
	property p_ls_off; !fused_load_switch_select[0] |-> reg_state[0] != LRC_LOAD_SWITCH; endproperty
	a_ls_off: assert property (p_ls_off) else $error("switch without fuse");
	property p_ls_on; fused_load_switch_select[2] |-> reg_state[2] != LRC_REGULATE; endproperty
	a_ls_on: assert property (p_ls_on) else $error("regulating with switch fuse");
	property p_rst_st;
		$fell(rst) |-> reg_state[0] == LRC_OFF_PULLDOWN ##3 reg_state[0] == (fused_in_sequence[0] ?
			(fused_load_switch_select[0] ? LRC_LOAD_SWITCH : LRC_REGULATE) : LRC_OFF_PULLDOWN);
	endproperty
	a_rst_st: assert property (p_rst_st) else $error("power-up state wrong");
	property p_rst_code; $fell(rst) |-> ##3 reg_code[3:0] == fused_voltage_default[3:0]; endproperty
	a_rst_code: assert property (p_rst_code) else $error("power-up code wrong");
	property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rd: assert property (p_rd) else $error("read answer late");
	property p_rdy; $fell(rst) |-> !s_axi_arready [*1] ##1 !s_axi_arready; endproperty
	a_rdy: assert property (p_rdy) else $error("ready too early after reset");
endmodule
bind lrc_top lrc_chk #(.N(N)) lrc_chk_inst (.core_clk, .rst, .fused_load_switch_select, .fused_voltage_default,
	.fused_in_sequence, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .reg_state, .reg_code, .reg_mv);

// file: test/tb_linear_regulator_control.sv
// Self-checking bench for the regulator control block over AXI4-Lite.
// Assumes four regulators; regulator two is index 1.
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
	$display("BAD %0t got %0h exp %0h", $time, g, e); end end
module tb_linear_regulator_control;
	import lrc_pkg::*;
	logic			core_clk = 0, rst = 1, pin_en = 0, pin_sel = 0;
	logic [3:0]		ls = 0, seq = 0, alt = 0, strb = 4'hf;
	logic [15:0]		dflt = 0, code, m_run, m_stb;
	logic [7:0]		awaddr = 0, araddr = 0, m_en;
	logic [31:0]		wdata = 0, rdata, rnd = 32'hc5ad;
	logic			awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic			awready, wready, bvalid, arready, rvalid;
	logic [1:0]		bresp, rresp, m_sys;
	lrc_state_t [3:0]	st;
	logic [51:0]		mv;
	int			err_total = 0, n_tests = 0;
	int			mvt[16] = '{1500, 1600, 1800, 1850, 2150, 2500, 2800, 3000,
					3100, 3150, 3200, 3300, 3350, 1650, 1700, 5000};
	lrc_top lrc_top_inst (.core_clk, .rst, .fused_load_switch_select(ls), .fused_voltage_default(dflt),
		.fused_in_sequence(seq), .fused_reg2_alt_code(alt), .second_regulator_enable_pin(pin_en),
		.voltage_choice_pin(pin_sel), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .reg_state(st), .reg_code(code), .reg_mv(mv));
	initial begin
		forever #5 core_clk = ~core_clk;
	end
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [1:0] exp_resp(input logic [7:0] a);
		return (a <= LRC_OFS_STATUS && a[1:0] == 2'h0) ? LRC_RESP_OKAY : LRC_RESP_SLVERR;
	endfunction
	function automatic logic [31:0] exp_rd(input logic [7:0] a, input logic [7:0] es);
		case (a)
			LRC_OFS_SYS:	return {30'h0, m_sys};
			LRC_OFS_ENABLE:	return {24'h0, m_en};
			LRC_OFS_RUN_V:	return {16'h0, m_run};
			LRC_OFS_STBY_V:	return {16'h0, m_stb};
			LRC_OFS_STATUS:	return {24'h0, es};
			default:	return 32'h0;
		endcase
	endfunction
	// Readies are looked at on the falling edge, so the handshake edge is known without a race
	task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
			output logic [1:0] r);
		logic ha, hw, ta, tw, done;
		ha = 0;
		hw = !wr;
		done = 0;
		if (wr) begin
			awaddr <= a;
			wdata <= d;
			awvalid <= 1;
			wvalid <= 1;
			bready <= 1;
		end else begin
			araddr <= a;
			arvalid <= 1;
			rready <= 1;
		end
		while (!done) begin
			@(negedge core_clk);
			ta = !ha && (wr ? awready : arready);
			tw = !hw && wready;
			done = wr ? bvalid : rvalid;
			q = rdata;
			r = wr ? bresp : rresp;
			@(posedge core_clk);
			if (ta) begin
				ha = 1;
				awvalid <= 0;
				arvalid <= 0;
			end
			if (tw) begin
				hw = 1;
				wvalid <= 0;
			end
		end
		bready <= 0;
		rready <= 0;
		@(posedge core_clk);
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic [1:0] r;
		axi(1, a, d, q, r);
		`CHK(r, exp_resp(a))
		case (a)
			LRC_OFS_SYS:	m_sys = d[1:0];
			LRC_OFS_ENABLE:	m_en = d[7:0];
			LRC_OFS_RUN_V:	m_run = d[15:0];
			LRC_OFS_STBY_V:	m_stb = d[15:0];
			default:	;
		endcase
	endtask
	task automatic check_out();
		logic [7:0] es;
		logic [15:0] ec;
		logic [51:0] em;
		logic e;
		logic [3:0] c;
		logic [31:0] q;
		logic [1:0] r;
		repeat (5) @(posedge core_clk);
		for (int i = 0; i < 4; i++) begin
			e = m_sys[0] ? m_en[4 + i] : m_en[i];
			c = m_sys[0] ? m_stb[4*i +: 4] : m_run[4*i +: 4];
			if (i == 1 && m_sys[1]) begin
				e = pin_en;
				c = pin_sel ? alt : c;
			end
			es[2*i +: 2] = !e ? LRC_OFF_PULLDOWN : ls[i] ? LRC_LOAD_SWITCH : LRC_REGULATE;
			ec[4*i +: 4] = c;
			em[13*i +: 13] = 13'(mvt[c]);
		end
		`CHK(st, es)
		`CHK(code, ec)
		`CHK(mv, em)
		for (int k = 0; k < 6; k++) begin
			axi(0, 8'(4 * k), 32'h0, q, r);
			`CHK(q, exp_rd(8'(4 * k), es))
			`CHK(r, exp_resp(8'(4 * k)))
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		#200000;
		err_total++;
		final_report();
	end
	initial begin
		for (int p = 0; p < 2; p++) begin
			rst <= 1;
			{ls, seq, alt, dflt} <= p ? rnd[27:0] : 28'h6393d0f;
			repeat (12) @(posedge core_clk);
			rst <= 0;
			m_sys = LRC_SYS_RST;
			m_en = {seq, seq};
			m_run = dflt;
			m_stb = dflt;
			check_out();
			for (int n = 0; n < 30; n++) begin
				rnd = lfsr(rnd);
				pin_en <= rnd[8];
				pin_sel <= rnd[9];
				wr_reg(8'(4 * (rnd[2:0] % 6)), lfsr(rnd));
				check_out();
			end
		end
		wr_reg(LRC_OFS_SYS, 32'h0);
		wr_reg(LRC_OFS_ENABLE, 32'hff);
		for (int c = 0; c < 16; c++) begin
			wr_reg(LRC_OFS_RUN_V, {16'h0, {4{4'(c)}}});
			check_out();
		end
		// Byte strobe: only the low byte of the run codes may change
		strb <= 4'h1;
		wr_reg(LRC_OFS_RUN_V, 32'h0000a505);
		m_run[15:8] = 8'hff;
		check_out();
		final_report();
	end
endmodule
